// ---- dv/ies_mem_model.sv ----
// Behavioural system memory holding vector tables, descriptors and stacks
`timescale 1ns/10ps
`default_nettype none
// ****
// Memory model
// ****
module ies_mem
(
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        MEM_REQ,
	input  wire logic        MEM_WE,
	input  wire logic        MEM_HALF,
	input  wire logic [31:0] MEM_ADDR,
	input  wire logic [31:0] MEM_WDATA,
	input  wire logic [3:0]  WAIT_CYC,
	output var  logic        MEM_ACK,
	output var  logic [31:0] MEM_RDATA
);
	logic [7:0] mem [logic [31:0]];
	logic [3:0] cnt_q;

	function automatic logic [31:0] peek(input logic [31:0] a);
		logic [31:0] v;
		for (int i = 0; i < 4; i++)
			v[8*i+:8] = mem.exists(a + i) ? mem[a + i] : 8'h00;
		return v;
	endfunction

	function automatic void put(input logic [31:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			mem[a + i] = d[8*i+:8];
	endfunction

	always @(posedge REF_CLK)
	begin
		MEM_ACK <= 1'b0;
		// Data stand only in the ack cycle; a toggling pattern exposes late sampling
		MEM_RDATA <= ~MEM_RDATA;
		if (SYS_RST)
		begin
			cnt_q <= 4'h0;
			MEM_RDATA <= 32'hA5A5_5A5A;
		end
		else if (MEM_REQ && !MEM_ACK)
		begin
			if (cnt_q < WAIT_CYC)
				cnt_q <= cnt_q + 4'h1;
			else
			begin
				cnt_q <= 4'h0;
				MEM_ACK <= 1'b1;
				MEM_RDATA <= peek(MEM_ADDR);
				if (MEM_WE && MEM_HALF)
				begin
					mem[MEM_ADDR] = MEM_WDATA[7:0];
					mem[MEM_ADDR + 32'h1] = MEM_WDATA[15:8];
				end
				else if (MEM_WE)
					put(MEM_ADDR, MEM_WDATA);
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/ies_seq_bench.sv ----
// Self-checking bench for the interrupt entry and return sequencer
`timescale 1ns/10ps
`default_nettype none
module ies_seq_bench;
	// ****
	// Signals
	// ****
	logic REF_CLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
	logic INT_REQ = 1'b0, INTERRUPT_RETURN_OP_REQ = 1'b0, INT_HAS_ERR = 1'b0, PMODE = 1'b0;
	logic [7:0] REG_ADDR = 8'h00, INT_VEC = 8'h00;
	logic [1:0] CPL_IN = 2'h0, outc;
	logic [3:0] WAIT_CYC = 4'h0;
	logic [15:0] CS_IN = 16'h0, SS_IN = 16'h0;
	logic [31:0] REG_WDATA = 32'h0, INT_ERR = 32'h0, FLAGS_IN = 32'h0;
	logic [31:0] EIP_IN = 32'h0, ESP_IN = 32'h0;
	logic [31:0] GDT_BASE = 32'h1000, LDT_BASE = 32'h2000, TSS_BASE = 32'h3000;
	wire logic MEM_REQ, MEM_WE, MEM_HALF, MEM_ACK, BUSY, DONE, FAULT, TASK_SWITCH;
	wire logic [31:0] REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, NEW_EIP, NEW_FLAGS;
	wire logic [31:0] NEW_ESP, HANDLER_LIN;
	wire logic [15:0] FAULT_CODE, TASK_SEL, NEW_CS, NEW_SS;
	wire logic [1:0] NEW_CPL;
	integer failures = 0, checked = 0, cycles = 0;
	logic [1:0] cpl_t [3] = '{2'h0, 2'h3, 2'h2};

	ies_seq uut (.REF_CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.INT_REQ, .INT_VEC, .INT_HAS_ERR, .INT_ERR, .INTERRUPT_RETURN_OP_REQ, .PMODE, .CPL_IN, .FLAGS_IN,
		.CS_IN, .EIP_IN, .SS_IN, .ESP_IN, .GDT_BASE, .LDT_BASE, .TSS_BASE, .MEM_REQ,
		.MEM_WE, .MEM_HALF, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA, .BUSY, .DONE,
		.FAULT, .FAULT_CODE, .TASK_SWITCH, .TASK_SEL, .NEW_CS, .NEW_EIP, .NEW_FLAGS,
		.NEW_SS, .NEW_ESP, .NEW_CPL, .HANDLER_LIN);
	ies_mem m (.REF_CLK, .SYS_RST, .MEM_REQ, .MEM_WE, .MEM_HALF, .MEM_ADDR, .MEM_WDATA,
		.WAIT_CYC, .MEM_ACK, .MEM_RDATA);

	always #20 REF_CLK = ~REF_CLK;

	task give_verdict;
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// A hung sequence would otherwise wait for the memory forever
	always @(posedge REF_CLK)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			give_verdict;
		end
	end

	// Wide enough for a selector beside a 32-bit pointer
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task pk(input logic [31:0] a, input logic [31:0] e);
		chk(m.peek(a), e);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge REF_CLK);
		#1;
		REG_WR <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge REF_CLK);
		#1;
		REG_RD <= 1'b0;
		chk(REG_RDATA, e);
	endtask

	task core(input logic pm, input logic [1:0] current_privilege, input logic [31:0] fl,
		input logic [15:0] cs, input logic [31:0] ip, input logic [15:0] ss,
		input logic [31:0] sp);
		PMODE <= pm;
		CPL_IN <= current_privilege;
		FLAGS_IN <= fl;
		CS_IN <= cs;
		EIP_IN <= ip;
		SS_IN <= ss;
		ESP_IN <= sp;
	endtask

	// Outcome codes: 1 done, 2 fault, 3 task switch
	task run(input logic irq, input logic [7:0] v, input logic he, input logic [1:0] eo);
		INT_VEC <= v;
		INT_HAS_ERR <= he;
		INT_ERR <= 32'h55AA;
		INT_REQ <= irq;
		INTERRUPT_RETURN_OP_REQ <= !irq;
		@(posedge REF_CLK);
		#1;
		INT_REQ <= 1'b0;
		INTERRUPT_RETURN_OP_REQ <= 1'b0;
		chk(64'(BUSY), 64'h1);
		outc = 2'h0;
		for (int n = 0; n < 300 && outc == 2'h0; n++)
		begin
			@(posedge REF_CLK);
			#1;
			if (DONE === 1'b1)
				outc = 2'h1;
			else if (FAULT === 1'b1)
				outc = 2'h2;
			else if (TASK_SWITCH === 1'b1)
				outc = 2'h3;
		end
		chk(32'(outc), 32'(eo));
	endtask

	// ****
	// Tests
	// ****
	initial
	begin
		repeat (12) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h0);
		wr(8'h00, 32'h100);
		m.put(32'h184, 32'h1234_5678);
		core(1'b0, 2'h0, 32'h302, 16'h0050, 32'h10, 16'h2000, 32'h100);
		run(1'b1, 8'h21, 1'b0, 2'h1);
		pk(32'h200FC, 32'h0302_0050);
		pk(32'h200FA, 32'h0050_0010);
		chk(32'(NEW_FLAGS[15:0]), 32'h2);
		chk(32'(NEW_CS), 32'h1234);
		chk(32'(NEW_EIP[15:0]), 32'h5678);
		chk(HANDLER_LIN, 32'h179B8);
		core(1'b0, 2'h0, 32'h2, 16'h1234, 32'h5678, 16'h2000, 32'hFA);
		run(1'b0, 8'h00, 1'b0, 2'h1);
		chk(32'(NEW_CS), 32'h50);
		chk(32'(NEW_EIP[15:0]), 32'h10);
		chk(32'(NEW_FLAGS[15:0]), 32'h302);
		chk(32'(NEW_ESP[15:0]), 32'h100);
		wr(8'h00, 32'h400);
		m.put(32'h468, 32'h000B_1234);
		m.put(32'h46C, 32'hABCD_EE00);
		m.put(32'h1008, 32'h0000_FFFF);
		m.put(32'h100C, 32'h00CF_9A10);
		core(1'b1, 2'h0, 32'h3_4302, 16'h0008, 32'h4000, 16'h0010, 32'h8000);
		run(1'b1, 8'h0D, 1'b1, 2'h1);
		pk(32'h7FFC, 32'h3_4302);
		pk(32'h7FF8, 32'h0008);
		pk(32'h7FF4, 32'h4000);
		pk(32'h7FF0, 32'h55AA);
		chk(NEW_FLAGS, 32'h2);
		chk({NEW_CS, NEW_EIP}, 48'h000B_ABCD_1234);
		chk(HANDLER_LIN, 32'hABDD_1234);
		core(1'b1, 2'h0, 32'h2, 16'h000B, 32'hABCD_1234, 16'h0010, 32'h7FF4);
		run(1'b0, 8'h00, 1'b0, 2'h1);
		chk({NEW_CS, NEW_EIP}, 48'h0008_0000_4000);
		chk(NEW_FLAGS, 32'h3_4302);
		chk(NEW_ESP, 32'h8000);
		WAIT_CYC <= 4'h3;
		m.put(32'h800, 32'h000C_5000);
		m.put(32'h804, 32'h0000_EF00);
		m.put(32'h2008, 32'h0000_FFFF);
		m.put(32'h200C, 32'h00CF_9A20);
		m.put(32'h3004, 32'h9000);
		m.put(32'h3008, 32'h0018);
		core(1'b1, 2'h3, 32'h202, 16'h001B, 32'h777, 16'h0023, 32'h6000);
		run(1'b1, 8'h80, 1'b0, 2'h1);
		pk(32'h8FFC, 32'h0023);
		pk(32'h8FF8, 32'h6000);
		pk(32'h8FF4, 32'h202);
		pk(32'h8FF0, 32'h001B);
		pk(32'h8FEC, 32'h777);
		chk({NEW_SS, NEW_ESP}, 48'h0018_0000_8FEC);
		chk(32'(NEW_CPL), 32'h0);
		chk(NEW_FLAGS, 32'h202);
		chk(HANDLER_LIN, 32'h0020_5000);
		core(1'b1, 2'h0, 32'h2, 16'h000C, 32'h5000, 16'h0018, 32'h8FEC);
		run(1'b0, 8'h00, 1'b0, 2'h1);
		chk({NEW_CS, NEW_EIP}, 48'h001B_0000_0777);
		chk({NEW_SS, NEW_ESP}, 48'h0023_0000_6000);
		chk(NEW_FLAGS, 32'h202);
		chk(32'(NEW_CPL), 32'h3);
		WAIT_CYC <= 4'h0;
		m.put(32'h428, 32'h0008_0000);
		m.put(32'h42C, 32'h0000_EC00);
		m.put(32'h430, 32'h0008_0000);
		m.put(32'h434, 32'h0000_8E00);
		m.put(32'h438, 32'h0010_0000);
		m.put(32'h43C, 32'h0000_EE00);
		m.put(32'h1010, 32'h0000_FFFF);
		m.put(32'h1014, 32'h00CF_FA00);
		for (int i = 0; i < 3; i++)
		begin
			core(1'b1, cpl_t[i], 32'h202, 16'h1B, 32'h1, 16'h23, 32'h6000);
			run(1'b1, 8'(5 + i), 1'b0, 2'h2);
			chk(32'(FAULT_CODE), 32'(8 * (5 + i) + 2));
		end
		rd(8'h08, 32'h3A);
		wr(8'h08, 32'hFFFF);
		rd(8'h08, 32'h3A);
		m.put(32'h440, 32'h0028_0000);
		m.put(32'h444, 32'h0000_E500);
		core(1'b1, 2'h3, 32'h202, 16'h1B, 32'h1, 16'h23, 32'h6000);
		run(1'b1, 8'h08, 1'b0, 2'h3);
		chk(32'(TASK_SEL), 32'h28);
		rd(8'h04, 32'h30);
		give_verdict;
	end
endmodule
`default_nettype wire

// ---- hdl/ies_params.svh ----
// Offsets, field positions, reset values and layout constants of the sequencer
`ifndef IES_PARAMS_SVH
`define IES_PARAMS_SVH
`define IES_REG_BASE  8'h00
`define IES_REG_STAT  8'h04
`define IES_REG_FCODE 8'h08
`define IES_BASE_RST  32'h0000_0000
`define IES_T_INT     4'hE
`define IES_T_TRAP    4'hF
`define IES_T_TASK    4'h5
`define IES_F_TF      8
`define IES_F_IF      9
`define IES_F_NT      14
`define IES_F_RF      16
`define IES_F_VM      17
`define IES_GATE_HI   32'h0000_0004
`define IES_TSS_ESP0  32'h0000_0004
`define IES_TSS_SS0   32'h0000_0008
`define IES_FC_TBL    3'h2
`define IES_LAST_RM   3'h4
`define IES_LAST_NOER 3'h4
`define IES_LAST_ERR  3'h5
`define IES_POP_SAME  3'h2
`define IES_POP_OUTER 3'h4
`endif

// ---- hdl/ies_pkg.sv ----
// Types shared by the interrupt entry and return sequencer
package ies_pkg;
	typedef enum logic [3:0]
	{
		S_IDLE = 4'h0,
		S_TBL  = 4'h1,
		S_GHI  = 4'h3,
		S_CLO  = 4'h2,
		S_CHI  = 4'h6,
		S_TSP  = 4'h7,
		S_TSS  = 4'h5,
		S_PUSH = 4'h4,
		S_POP  = 4'hC
	} ies_state_t;

	typedef struct packed
	{
		ies_state_t  st;
		logic [2:0]  step;
		logic [7:0]  vec;
		logic        has_err;
		logic [31:0] err;
		logic        pm;
		logic [1:0]  current_privilege;
		logic [3:0]  gtype;
		logic [1:0]  gdpl;
		logic [15:0] gsel;
		logic [31:0] goff;
		logic [31:0] cbase;
		logic [1:0]  cdpl;
		logic [31:0] flags;
		logic [15:0] cs;
		logic [31:0] instruction_pointer_32;
		logic [15:0] ss;
		logic [31:0] stack_pointer_32;
		logic [15:0] nss;
		logic [31:0] nesp;
		logic [31:0] base;
		logic        done;
		logic        fault;
		logic [15:0] fcode;
		logic        tsw;
		logic [31:0] rdat;
	} ies_regs_t;
endpackage

// ---- hdl/ies_seq.sv ----
// Interrupt entry and interrupt return sequencer, real and protected mode
//
// Behaviour
// RULE_01 - Real table: 256 four-byte far pointers
// RULE_02 - Reset clears the table base
// RULE_03 - Real entry: push flags, clear IF TF, push CS IP
// RULE_04 - Real pointer at base plus vector times four
// RULE_05 - Real return pops IP, CS, then flags
// RULE_06 - Protected table: 256 eight-byte gates, vector times eight
// RULE_07 - Only interrupt, trap, task gates; else fault
// RULE_08 - Task gate requests a task switch
// RULE_09 - Handler address is code base plus offset
// RULE_10 - Push full flags, clear TF NT RF VM
// RULE_11 - Interrupt gate clears IF, trap keeps it
// RULE_12 - Push padded CS then 32-bit IP
// RULE_13 - Push error code after return pointer
// RULE_14 - Load CS and IP from the gate
// RULE_15 - Inner level picks new stack from record
// RULE_16 - Privilege raise pushes old SS and SP first
// RULE_17 - Current privilege must not exceed gate's; code checks it for interrupt and trap gates only
// RULE_18 - No transfer to a less privileged handler
// RULE_19 - No requested-privilege check on entry
// RULE_20 - Either failed check denies the transfer
// RULE_21 - Same-level return pops IP, CS, flags
// RULE_22 - Outer return also pops SP and SS
// RULE_23 - Denial reports fault naming the table entry
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "ies_params.svh"

module ies_seq
(
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	input  wire logic        INT_REQ,
	input  wire logic [7:0]  INT_VEC,
	input  wire logic        INT_HAS_ERR,
	input  wire logic [31:0] INT_ERR,
	input  wire logic        INTERRUPT_RETURN_OP_REQ,
	input  wire logic        PMODE,
	input  wire logic [1:0]  CPL_IN,
	input  wire logic [31:0] FLAGS_IN,
	input  wire logic [15:0] CS_IN,
	input  wire logic [31:0] EIP_IN,
	input  wire logic [15:0] SS_IN,
	input  wire logic [31:0] ESP_IN,
	input  wire logic [31:0] GDT_BASE,
	input  wire logic [31:0] LDT_BASE,
	input  wire logic [31:0] TSS_BASE,
	output logic             MEM_REQ,
	output logic             MEM_WE,
	output logic             MEM_HALF,
	output logic      [31:0] MEM_ADDR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic        MEM_ACK,
	input  wire logic [31:0] MEM_RDATA,
	output logic             BUSY,
	output logic             DONE,
	output logic             FAULT,
	output logic      [15:0] FAULT_CODE,
	output logic             TASK_SWITCH,
	output logic      [15:0] TASK_SEL,
	output logic      [15:0] NEW_CS,
	output logic      [31:0] NEW_EIP,
	output logic      [31:0] NEW_FLAGS,
	output logic      [15:0] NEW_SS,
	output logic      [31:0] NEW_ESP,
	output logic      [1:0]  NEW_CPL,
	output logic      [31:0] HANDLER_LIN
);
	ies_pkg::ies_regs_t q;
	ies_pkg::ies_regs_t d;

	// Real mode stacks are segment times 16 plus offset; protected stacks are flat
	function automatic logic [31:0] stk(input logic pm, input logic [15:0] s,
		input logic [31:0] o);
		stk = pm ? o : ({12'h0, s, 4'h0} + {16'h0, o[15:0]});
	endfunction

	function automatic logic [31:0] dtbl(input logic [15:0] sel);
		dtbl = (sel[2] ? LDT_BASE : GDT_BASE) + {16'h0, sel[15:3], 3'h0};
	endfunction

	logic [31:0] push_w;
	logic [31:0] push_sp;
	logic [31:0] pop_sp;
	logic [31:0] fl_new;
	logic [2:0]  push_last;
	logic        gate_ok;

	// ****************************************************************
	// Memory side
	// ****************************************************************
	always_comb
	begin
		push_sp = q.nesp - (q.pm ? 32'h0000_0004 : 32'h0000_0002);
		pop_sp = q.nesp + (q.pm ? 32'h0000_0004 : 32'h0000_0002);
		unique case (q.step)
			3'h0: push_w = {16'h0, q.nss == q.ss ? q.ss : q.ss}; // RULE_16
			3'h1: push_w = q.stack_pointer_32; // RULE_16
			3'h2: push_w = q.pm ? q.flags : {16'h0, q.flags[15:0]}; // RULE_03 RULE_10
			3'h3: push_w = {16'h0, q.cs}; // RULE_12
			3'h4: push_w = q.pm ? q.instruction_pointer_32 : {16'h0, q.instruction_pointer_32[15:0]}; // RULE_12
			default: push_w = q.err; // RULE_13
		endcase
		push_last = !q.pm ? `IES_LAST_RM : (q.has_err ? `IES_LAST_ERR : `IES_LAST_NOER);
		gate_ok = q.gtype == `IES_T_INT || q.gtype == `IES_T_TRAP;
		MEM_REQ = q.st != ies_pkg::S_IDLE;
		MEM_WE = q.st == ies_pkg::S_PUSH;
		MEM_HALF = !q.pm && (q.st == ies_pkg::S_PUSH || q.st == ies_pkg::S_POP);
		MEM_WDATA = MEM_WE ? push_w : 32'h0;
		unique case (q.st)
			ies_pkg::S_TBL:
				MEM_ADDR = q.base + (q.pm ? {21'h0, q.vec, 3'h0} // RULE_06
					: {22'h0, q.vec, 2'h0}); // RULE_01 RULE_04
			ies_pkg::S_GHI: MEM_ADDR = q.base + {21'h0, q.vec, 3'h0} + `IES_GATE_HI;
			ies_pkg::S_CLO: MEM_ADDR = dtbl(q.gsel); // RULE_09
			ies_pkg::S_CHI: MEM_ADDR = dtbl(q.gsel) + `IES_GATE_HI;
			ies_pkg::S_TSP: MEM_ADDR = TSS_BASE + `IES_TSS_ESP0 + {27'h0, q.cdpl, 3'h0}; // RULE_15
			ies_pkg::S_TSS: MEM_ADDR = TSS_BASE + `IES_TSS_SS0 + {27'h0, q.cdpl, 3'h0}; // RULE_15
			ies_pkg::S_PUSH: MEM_ADDR = stk(q.pm, q.nss, push_sp);
			ies_pkg::S_POP: MEM_ADDR = stk(q.pm, q.nss, q.nesp);
			default: MEM_ADDR = 32'h0;
		endcase
		fl_new = q.flags;
		if (q.pm)
		begin
			fl_new[`IES_F_TF] = 1'b0; // RULE_10
			fl_new[`IES_F_NT] = 1'b0;
			fl_new[`IES_F_RF] = 1'b0;
			fl_new[`IES_F_VM] = 1'b0;
			if (q.gtype == `IES_T_INT)
				fl_new[`IES_F_IF] = 1'b0; // RULE_11
		end
		else
		begin
			fl_new[`IES_F_TF] = 1'b0; // RULE_03
			fl_new[`IES_F_IF] = 1'b0;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.fault = 1'b0;
		d.tsw = 1'b0;
		if (REG_WR && REG_ADDR == `IES_REG_BASE)
			d.base = REG_WDATA;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				`IES_REG_BASE: d.rdat = q.base;
				`IES_REG_STAT: d.rdat = {25'h0, MEM_REQ, q.current_privilege, q.st};
				`IES_REG_FCODE: d.rdat = {16'h0, q.fcode};
				default: d.rdat = 32'h0;
			endcase
		end
		unique case (q.st)
			ies_pkg::S_IDLE:
				if (INT_REQ)
				begin
					d.vec = INT_VEC;
					d.has_err = INT_HAS_ERR;
					d.err = INT_ERR;
					d.pm = PMODE;
					d.current_privilege = CPL_IN;
					d.flags = FLAGS_IN;
					d.cs = CS_IN;
					d.instruction_pointer_32 = EIP_IN;
					d.ss = SS_IN;
					d.stack_pointer_32 = ESP_IN;
					d.nss = SS_IN;
					d.nesp = ESP_IN;
					d.st = ies_pkg::S_TBL;
				end
				else if (INTERRUPT_RETURN_OP_REQ)
				begin
					d.pm = PMODE;
					d.current_privilege = CPL_IN;
					d.flags = FLAGS_IN;
					d.ss = SS_IN;
					d.stack_pointer_32 = ESP_IN;
					d.nss = SS_IN;
					d.nesp = ESP_IN;
					d.step = 3'h0;
					d.st = ies_pkg::S_POP;
				end
			ies_pkg::S_TBL:
				if (MEM_ACK)
				begin
					d.goff = {16'h0, MEM_RDATA[15:0]};
					d.gsel = MEM_RDATA[31:16];
					d.gtype = `IES_T_INT;
					d.step = 3'h2;
					d.cbase = {12'h0, MEM_RDATA[31:16], 4'h0};
					d.st = q.pm ? ies_pkg::S_GHI : ies_pkg::S_PUSH;
				end
			ies_pkg::S_GHI:
				if (MEM_ACK)
				begin
					d.gtype = MEM_RDATA[11:8];
					d.gdpl = MEM_RDATA[14:13];
					d.goff[31:16] = MEM_RDATA[31:16];
					if (MEM_RDATA[11:8] == `IES_T_TASK)
					begin
						d.tsw = 1'b1; // RULE_08
						d.st = ies_pkg::S_IDLE;
					end
					else if ((MEM_RDATA[11:8] != `IES_T_INT && MEM_RDATA[11:8] != `IES_T_TRAP)
						|| q.current_privilege > MEM_RDATA[14:13]) // RULE_07 RULE_17 RULE_19
					begin
						d.fault = 1'b1; // RULE_20
						d.fcode = {5'h0, q.vec, `IES_FC_TBL}; // RULE_23
						d.st = ies_pkg::S_IDLE;
					end
					else
						d.st = ies_pkg::S_CLO;
				end
			ies_pkg::S_CLO:
				if (MEM_ACK)
				begin
					d.cbase[15:0] = MEM_RDATA[31:16];
					d.st = ies_pkg::S_CHI;
				end
			ies_pkg::S_CHI:
				if (MEM_ACK)
				begin
					d.cbase[31:16] = {MEM_RDATA[31:24], MEM_RDATA[7:0]}; // RULE_09
					d.cdpl = MEM_RDATA[14:13];
					d.step = 3'h2;
					if (q.current_privilege < MEM_RDATA[14:13]) // RULE_18
					begin
						d.fault = 1'b1; // RULE_20
						d.fcode = {5'h0, q.vec, `IES_FC_TBL}; // RULE_23
						d.st = ies_pkg::S_IDLE;
					end
					else if (MEM_RDATA[14:13] < q.current_privilege)
						d.st = ies_pkg::S_TSP; // RULE_15
					else
						d.st = ies_pkg::S_PUSH;
				end
			ies_pkg::S_TSP:
				if (MEM_ACK)
				begin
					d.nesp = MEM_RDATA;
					d.st = ies_pkg::S_TSS;
				end
			ies_pkg::S_TSS:
				if (MEM_ACK)
				begin
					d.nss = MEM_RDATA[15:0];
					d.step = 3'h0; // RULE_16
					d.st = ies_pkg::S_PUSH;
				end
			ies_pkg::S_PUSH:
				if (MEM_ACK)
				begin
					d.nesp = push_sp;
					d.step = q.step + 3'h1;
					if (q.step == push_last)
					begin
						d.flags = fl_new;
						d.cs = q.gsel; // RULE_14
						d.instruction_pointer_32 = q.goff; // RULE_14
						d.ss = q.nss;
						d.stack_pointer_32 = push_sp;
						if (q.pm)
							d.current_privilege = q.cdpl;
						d.done = 1'b1;
						d.st = ies_pkg::S_IDLE;
					end
				end
			ies_pkg::S_POP:
				if (MEM_ACK)
				begin
					d.nesp = pop_sp;
					d.step = q.step + 3'h1;
					unique case (q.step)
						3'h0: d.instruction_pointer_32 = q.pm ? MEM_RDATA : {q.instruction_pointer_32[31:16], MEM_RDATA[15:0]};
						3'h1: d.cs = MEM_RDATA[15:0];
						3'h2: d.flags = q.pm ? MEM_RDATA : {q.flags[31:16], MEM_RDATA[15:0]};
						3'h3: d.stack_pointer_32 = MEM_RDATA; // RULE_22
						default: d.ss = MEM_RDATA[15:0]; // RULE_22
					endcase
					if (q.step == `IES_POP_OUTER
						|| (q.step == `IES_POP_SAME
						&& (!q.pm || q.cs[1:0] <= q.current_privilege))) // RULE_05 RULE_21
					begin
						if (q.step == `IES_POP_SAME)
							d.stack_pointer_32 = pop_sp;
						if (q.pm)
							d.current_privilege = q.cs[1:0];
						d.done = 1'b1;
						d.st = ies_pkg::S_IDLE;
					end
				end
			default: d.st = ies_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			q <= '0;
			q.base <= `IES_BASE_RST; // RULE_02
		end
		else
			q <= d;
	end

	always_comb
	begin
		REG_RDATA = q.rdat;
		BUSY = MEM_REQ;
		DONE = q.done;
		FAULT = q.fault;
		FAULT_CODE = q.fcode;
		TASK_SWITCH = q.tsw;
		TASK_SEL = q.gsel;
		NEW_CS = q.cs;
		NEW_EIP = q.instruction_pointer_32;
		NEW_FLAGS = q.flags;
		NEW_SS = q.ss;
		NEW_ESP = q.stack_pointer_32;
		NEW_CPL = q.current_privilege;
		HANDLER_LIN = q.pm ? q.cbase + q.goff : q.cbase + {16'h0, q.goff[15:0]}; // RULE_09
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	property p_base_rst;
		disable iff (1'b0) SYS_RST |=> q.base == 32'h0;
	endproperty
	a_base_rst: assert property (p_base_rst) else $error("table base not cleared"); // RULE_02

	property p_rm_tbl;
		q.st == ies_pkg::S_TBL && !q.pm |-> MEM_ADDR == q.base + {22'h0, q.vec, 2'h0};
	endproperty
	a_rm_tbl: assert property (p_rm_tbl) else $error("real vector address wrong"); // RULE_04

	property p_pm_tbl;
		q.st == ies_pkg::S_TBL && q.pm |-> MEM_ADDR == q.base + {21'h0, q.vec, 3'h0};
	endproperty
	a_pm_tbl: assert property (p_pm_tbl) else $error("gate address wrong"); // RULE_06

	sequence s_gate_hi;
		q.st == ies_pkg::S_GHI && MEM_ACK;
	endsequence

	property p_bad_type;
		s_gate_hi and (MEM_RDATA[11:8] != `IES_T_INT && MEM_RDATA[11:8] != `IES_T_TRAP
			&& MEM_RDATA[11:8] != `IES_T_TASK) |=> FAULT && !DONE;
	endproperty
	a_bad_type: assert property (p_bad_type) else $error("bad gate not faulted"); // RULE_07

	property p_task;
		s_gate_hi and MEM_RDATA[11:8] == `IES_T_TASK |=> TASK_SWITCH && TASK_SEL == $past(q.gsel);
	endproperty
	a_task: assert property (p_task) else $error("task gate not switched"); // RULE_08

	property p_gate_priv;
		s_gate_hi and gate_ok && q.current_privilege > MEM_RDATA[14:13]
			|=> FAULT && FAULT_CODE == {5'h0, q.vec, `IES_FC_TBL};
	endproperty
	a_gate_priv: assert property (p_gate_priv) else $error("gate privilege not denied"); // RULE_23

	property p_raise_push;
		$rose(q.st == ies_pkg::S_PUSH) && q.step == 3'h0 |-> MEM_WDATA == {16'h0, q.ss};
	endproperty
	a_raise_push: assert property (p_raise_push) else $error("old stack not pushed first"); // RULE_16

	property p_pm_flags;
		DONE && q.pm && $past(q.st) == ies_pkg::S_PUSH |-> !NEW_FLAGS[`IES_F_TF]
			&& !NEW_FLAGS[`IES_F_NT] && !NEW_FLAGS[`IES_F_RF] && !NEW_FLAGS[`IES_F_VM];
	endproperty
	a_pm_flags: assert property (p_pm_flags) else $error("entry flags not cleared"); // RULE_10

	property p_rm_flags;
		DONE && !q.pm && $past(q.st) == ies_pkg::S_PUSH
			|-> !NEW_FLAGS[`IES_F_TF] && !NEW_FLAGS[`IES_F_IF];
	endproperty
	a_rm_flags: assert property (p_rm_flags) else $error("real entry flags not cleared"); // RULE_03
endmodule
`default_nettype wire
